// [shared/eit_regs.svh]
// Purpose: register offsets, field positions and reset values of the interval timer
// Assumes: byte-wide special function register port, addresses as printed
// Notes:   compare and count registers get offsets of our own
`ifndef EIT_REGS_SVH
`define EIT_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EIT_ADDR_MODE_CONTROL   16'hff78
`define EIT_ADDR_CLOCK_SELECT   16'hff79
`define EIT_ADDR_COMPARE_VALUE  16'hff7a
`define EIT_ADDR_COUNT_VALUE    16'hff7b

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define EIT_BIT_COUNT_ENABLE    7
`define EIT_BIT_TOGGLE_ENABLE   1
`define EIT_MODE_WRITE_MASK     8'h82
`define EIT_SEL_WRITE_MASK      8'h07

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EIT_RST_MODE_CONTROL    8'h00
`define EIT_RST_CLOCK_SELECT    8'h00
`define EIT_RST_COMPARE_VALUE   8'h00
`define EIT_RST_COUNT_VALUE     8'h00

// ----------------------------------------------------------------
// prescaler tap positions (divide by 2^(n+1) taps bit n)
// ----------------------------------------------------------------
`define EIT_TAP_DIV8            3'h2
`define EIT_TAP_DIV16           3'h3
`define EIT_TAP_DIV32           3'h4
`define EIT_TAP_DIV128          4'h6
`define EIT_TAP_DIV512          4'h8
`define EIT_TAP_DIV2048         4'ha

`endif

// [shared/eit_pkg.sv]
// Purpose: types shared by the interval timer modules
// Assumes: nothing
// Notes:   constants live in eit_regs.svh
package eit_pkg;

   // ----------------------------------------------------------------
   // clock select codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EIT_SEL_OFF0   = 3'h0,
      EIT_SEL_OFF1   = 3'h1,
      EIT_SEL_DIV8   = 3'h2,
      EIT_SEL_DIV16  = 3'h3,
      EIT_SEL_DIV32  = 3'h4,
      EIT_SEL_DIV128 = 3'h5,
      EIT_SEL_DIV512 = 3'h6,
      EIT_SEL_DIV2K  = 3'h7
   } eit_sel_t;

   typedef logic [7:0] eit_byte_t;

endpackage

// [shared/eit_tick_if.sv]
// Purpose: carries prescaler control and tick between timer modules
// Assumes: single clock domain
// Notes:   run clears the prescaler when low
`timescale 1ns/100ps
interface eit_tick_if;
   import eit_pkg::*;
   logic     run;
   eit_sel_t sel;
   logic     tick;

   modport core (output run, output sel, input tick);
   modport pre  (input run, input sel, output tick);
endinterface

// [hdl/eit_prescaler.sv]
// Purpose: divides the system clock and emits one-cycle count ticks
// Assumes: sel is held steady while run is high
// Notes:   prohibited codes give no tick
`timescale 1ns/100ps
`include "eit_regs.svh"
module eit_prescaler #(
   parameter int DIV_WIDTH = 11
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   eit_tick_if.pre   tk
);
   import eit_pkg::*;

   logic [DIV_WIDTH-1:0] div_q, div_d;
   logic                 tap_q, tap_d;
   logic                 tick_q, tick_d;

   // tap index for a select code
   function automatic logic [3:0] tap_of(input eit_sel_t s);
      unique case (s)
         EIT_SEL_DIV8:   tap_of = 4'(`EIT_TAP_DIV8);
         EIT_SEL_DIV16:  tap_of = 4'(`EIT_TAP_DIV16);
         EIT_SEL_DIV32:  tap_of = 4'(`EIT_TAP_DIV32);
         EIT_SEL_DIV128: tap_of = `EIT_TAP_DIV128;
         EIT_SEL_DIV512: tap_of = `EIT_TAP_DIV512;
         EIT_SEL_DIV2K:  tap_of = `EIT_TAP_DIV2048;
         default:        tap_of = 4'h0;
      endcase
   endfunction

   // next divider, tap and tick; a tick on each falling edge of the tap while run is high and the select code is legal
   always_comb begin
      logic legal;
      legal  = (tk.sel != EIT_SEL_OFF0) && (tk.sel != EIT_SEL_OFF1);
      div_d  = tk.run ? div_q + 1'b1 : '0;
      tap_d  = tk.run ? div_q[tap_of(tk.sel)] : 1'b0;
      tick_d = tk.run && legal && tap_q && !div_q[tap_of(tk.sel)]; // see R06
   end

   // registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         div_q  <= '0;
         tap_q  <= 1'b0;
         tick_q <= 1'b0;
      end else if (clk_en) begin
         div_q  <= div_d;
         tap_q  <= tap_d;
         tick_q <= tick_d;
      end
   end

   assign tk.tick = tick_q && clk_en;
endmodule

// [hdl/eit_timer.sv]
// Purpose: 8-bit interval timer with compare, interrupt and output toggle
// Assumes: byte register port; software stops the timer before reconfiguring
// Notes:   match pulse and toggle output feed interrupt and meter logic
//
// Function
// R01: match raises request, clears counter, keeps counting
// R02: period is compare value plus one ticks
// R03: compare register written only as whole byte
// R04: reset loads compare register with zero
// R05: counter readable as byte, reset to zero
// R06: select code picks prescaled count clock
// R07: software stops timer before changing select
// R08: enable bit starts counting; clearing clears counter
// R09: toggle enable bit lets match invert output
// R10: software stops timer before writing mode register
// R11: software writes zero to unused mode bits
// R12: mode register resets to zero
// R13: software sets toggle enable for meter clock
// R14: counter advances per tick; output starts low
`timescale 1ns/100ps
`include "eit_regs.svh"
module eit_timer (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   input  wire logic [15:0]       reg_addr,
   input  wire logic              reg_wr,
   input  wire eit_pkg::eit_byte_t reg_wdata,
   output      eit_pkg::eit_byte_t reg_rdata,
   output      logic              interval_match_irq,
   output      logic              toggle_out
);
   import eit_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   eit_byte_t mode_q, mode_d;
   eit_byte_t sel_q, sel_d;
   eit_byte_t cmp_q, cmp_d;
   eit_byte_t cnt_q, cnt_d;
   eit_byte_t rdata_q, rdata_d;
   logic      irq_q, irq_d;
   logic      tog_q, tog_d;
   logic      run;
   logic      match;

   eit_tick_if tk ();

   // prescaler shares the system clock with the core
   eit_prescaler #(
      .DIV_WIDTH (11)
   ) u_pre (
      .clock   (clock),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .tk      (tk)
   );

   assign run    = mode_q[`EIT_BIT_COUNT_ENABLE];
   assign tk.run = run;                        // see R08
   assign tk.sel = eit_sel_t'(sel_q[2:0]);     // see R06

   // compare on a tick: the tick that arrives while the counter equals compare clears it
   assign match = run && tk.tick && (cnt_q == cmp_q); // see R02

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_comb begin
      mode_d = mode_q;
      sel_d  = sel_q;
      cmp_d  = cmp_q;
      if (reg_wr) begin
         unique case (reg_addr)
            `EIT_ADDR_MODE_CONTROL:  mode_d = reg_wdata & `EIT_MODE_WRITE_MASK;
            `EIT_ADDR_CLOCK_SELECT:  sel_d  = reg_wdata & `EIT_SEL_WRITE_MASK;
            `EIT_ADDR_COMPARE_VALUE: cmp_d  = reg_wdata; // see R03
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // counter, interrupt and toggle
   // ----------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      irq_d = 1'b0;
      tog_d = tog_q;
      if (!run) begin
         cnt_d = '0;                          // see R08
      end else if (match) begin
         cnt_d = '0;                          // see R01
         irq_d = 1'b1;                        // see R01
         if (mode_q[`EIT_BIT_TOGGLE_ENABLE]) begin
            tog_d = !tog_q;                   // see R09
         end
      end else if (tk.tick) begin
         cnt_d = cnt_q + 8'h01;               // see R14
      end
   end

   // ----------------------------------------------------------------
   // read mux, registered
   // ----------------------------------------------------------------
   always_comb begin
      unique case (reg_addr)
         `EIT_ADDR_MODE_CONTROL:  rdata_d = mode_q;
         `EIT_ADDR_CLOCK_SELECT:  rdata_d = sel_q;
         `EIT_ADDR_COMPARE_VALUE: rdata_d = cmp_q;
         `EIT_ADDR_COUNT_VALUE:   rdata_d = cnt_q; // see R05
         default:                 rdata_d = 8'h00;
      endcase
   end

   // registers with reset values
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_q  <= `EIT_RST_MODE_CONTROL;    // see R12
         sel_q   <= `EIT_RST_CLOCK_SELECT;
         cmp_q   <= `EIT_RST_COMPARE_VALUE;   // see R04
         cnt_q   <= `EIT_RST_COUNT_VALUE;     // see R05
         rdata_q <= 8'h00;
         irq_q   <= 1'b0;
         tog_q   <= 1'b0;                     // see R14
      end else if (clk_en) begin
         mode_q  <= mode_d;
         sel_q   <= sel_d;
         cmp_q   <= cmp_d;
         cnt_q   <= cnt_d;
         rdata_q <= rdata_d;
         irq_q   <= irq_d;
         tog_q   <= tog_d;
      end
   end

   assign reg_rdata          = rdata_q;
   assign interval_match_irq = irq_q && clk_en;
   assign toggle_out         = tog_q;
endmodule

// [testbench/eit_timer_props.sv]
// Purpose: port checks of the interval timer
// Assumes: register map of eit_regs.svh
// Notes:   bound to eit_timer below
`timescale 1ns/100ps
`include "eit_regs.svh"
module eit_timer_props (
   input logic               clock,
   input logic               sys_rst,
   input logic               clk_en,
   input logic [15:0]        reg_addr,
   input logic               reg_wr,
   input eit_pkg::eit_byte_t reg_wdata,
   input eit_pkg::eit_byte_t reg_rdata,
   input logic               interval_match_irq,
   input logic               toggle_out
);
   import eit_pkg::*;
   eit_byte_t   mode_q, sel_q, cmp_q;
   logic [19:0] gap_q, per;
   logic        stop, irq;
   assign irq  = interval_match_irq;
   assign stop = !mode_q[7] || sel_q[2:1] == 2'h0;
   assign per  = (20'(cmp_q) + 20'h1) << (sel_q[2] ? {sel_q[1:0], 1'b1} + 4'h4
                                                   : {2'h0, sel_q[1:0]} + 4'h1);
   // shadow registers and cycles since last request, 0 while unknown
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_q <= 8'h00;
         sel_q  <= 8'h00;
         cmp_q  <= 8'h00;
         gap_q  <= 20'h0;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == `EIT_ADDR_MODE_CONTROL) mode_q <= reg_wdata;
         if (reg_wr && reg_addr == `EIT_ADDR_CLOCK_SELECT) sel_q <= reg_wdata;
         if (reg_wr && reg_addr == `EIT_ADDR_COMPARE_VALUE) cmp_q <= reg_wdata;
         gap_q <= reg_wr ? 20'h0 : irq ? 20'h1 : gap_q == 20'h0 ? gap_q : gap_q + 20'h1;
      end
   end
   // ----
   // properties
   // ----
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_pulse; irq |=> !irq; endproperty
   a_pulse: assert property (p_pulse)
      else $error("irq too wide");
   property p_rst; disable iff (1'b0)
      sys_rst && clk_en |=> reg_rdata == 8'h00 && !irq && !toggle_out; endproperty
   a_rst: assert property (p_rst)
      else $error("bad reset state");
   property p_cmp; (clk_en && reg_wr && reg_addr == `EIT_ADDR_COMPARE_VALUE ##1 clk_en
      && !reg_wr && reg_addr == `EIT_ADDR_COMPARE_VALUE) |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("compare readback");
   property p_stop; !mode_q[7] && clk_en && reg_addr == `EIT_ADDR_COUNT_VALUE
      |=> reg_rdata == 8'h00; endproperty
   a_stop: assert property (p_stop)
      else $error("count not clear");
   property p_quiet; stop && $past(stop) && $past(stop, 2) |-> !irq; endproperty
   a_quiet: assert property (p_quiet)
      else $error("irq while stopped");
   property p_hold; !mode_q[1] && !$past(mode_q[1]) && !$past(mode_q[1], 2)
      |-> $stable(toggle_out); endproperty
   a_hold: assert property (p_hold)
      else $error("toggle while disabled");
   property p_tgl; !$past(sys_rst) && $changed(toggle_out)
      |-> ($past(irq) or ##[0:1] irq); endproperty
   a_tgl: assert property (p_tgl)
      else $error("toggle without match");
   property p_period; irq && gap_q != 20'h0 |-> gap_q == per; endproperty
   a_period: assert property (p_period)
      else $error("wrong interval");
   c_period: cover property (irq && gap_q != 20'h0);
   c_tgl: cover property ($changed(toggle_out));
   c_stop: cover property (!mode_q[7] && reg_addr == `EIT_ADDR_COUNT_VALUE);
endmodule
bind eit_timer eit_timer_props i_eit_timer_props (.clock(clock), .sys_rst(sys_rst),
   .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .interval_match_irq(interval_match_irq), .toggle_out(toggle_out));

// [testbench/eit_timer_tb_top.sv]
// Purpose: self-checking bench of the interval timer
// Assumes: clk_en held high throughout
// Notes:   select codes 2 to 7 timed over a full interval
`timescale 1ns/100ps
`include "eit_regs.svh"
module eit_timer_tb_top;
   import eit_pkg::*;
   logic        clock, sys_rst, clk_en, reg_wr, interval_match_irq, toggle_out;
   logic [15:0] reg_addr;
   eit_byte_t   reg_wdata, reg_rdata;
   int          error_cnt = 0, cmp_count = 0;
   eit_timer i_eit_timer (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .interval_match_irq(interval_match_irq), .toggle_out(toggle_out));
   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ----
   // helpers
   // ----
   task automatic finish_test;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [19:0] got, logic [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [15:0] a, eit_byte_t d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wr    <= 1'b1;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [15:0] a, eit_byte_t e);
      @(posedge clock);
      reg_addr <= a;
      @(posedge clock);
      #1 chk("rdata", reg_rdata, e);
   endtask
   // edges until the next request, bounded
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (interval_match_irq !== 1'b1 && n < 9000);
      if (n >= 9000) begin
         error_cnt++;
         finish_test();
      end
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset;
      rd(`EIT_ADDR_MODE_CONTROL, 8'h00);
      rd(`EIT_ADDR_CLOCK_SELECT, 8'h00);
      rd(`EIT_ADDR_COMPARE_VALUE, 8'h00);
      rd(`EIT_ADDR_COUNT_VALUE, 8'h00);
      rd(16'hff7c, 8'h00);
   endtask
   task automatic t_mask;
      wr(`EIT_ADDR_MODE_CONTROL, 8'h02);
      rd(`EIT_ADDR_MODE_CONTROL, 8'h02);
      wr(`EIT_ADDR_MODE_CONTROL, 8'h00);
      rd(`EIT_ADDR_MODE_CONTROL, 8'h00);
      wr(`EIT_ADDR_CLOCK_SELECT, 8'hf8);
      rd(`EIT_ADDR_CLOCK_SELECT, 8'h00);
      wr(`EIT_ADDR_COUNT_VALUE, 8'h5a);
      rd(`EIT_ADDR_COUNT_VALUE, 8'h00);
   endtask
   task automatic t_run(eit_byte_t s, eit_byte_t c, logic t, int sh);
      int   p;
      logic was;
      wr(`EIT_ADDR_CLOCK_SELECT, s);
      wr(`EIT_ADDR_COMPARE_VALUE, c);
      rd(`EIT_ADDR_COMPARE_VALUE, c);
      wr(`EIT_ADDR_MODE_CONTROL, {1'b1, 5'h0, t, 1'b0});
      wait_irq(p);
      wait_irq(p);
      chk("period", 20'(p), (20'(c) + 20'h1) << sh);
      repeat (2) @(posedge clock);
      #1 was = toggle_out;
      wait_irq(p);
      repeat (2) @(posedge clock);
      #1 chk("toggle", 20'(toggle_out), 20'(was ^ t));
      wr(`EIT_ADDR_MODE_CONTROL, 8'h00);
      rd(`EIT_ADDR_COUNT_VALUE, 8'h00);
   endtask
   // main sequence
   initial begin
      sys_rst   = 1'b1;
      clk_en    = 1'b1;
      reg_addr  = 16'h0000;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_mask();
      t_run(8'h02, 8'hff, 1'b0, 3);
      t_run(8'h03, 8'h00, 1'b1, 4);
      t_run(8'h04, 8'h01, 1'b0, 5);
      t_run(8'h05, 8'h01, 1'b1, 7);
      t_run(8'h06, 8'h01, 1'b0, 9);
      t_run(8'h07, 8'h01, 1'b1, 11);
      finish_test();
   end
endmodule
